// file: hdl/i2cas_ctrl.sv
// i2c controller core: master with repeated start, clock sync, arbitration, slave address detect
// assumes an apb master on pclk and open-drain scl/sda resolved outside (oe_n low = pull low)
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps

// How it works
// - master may restart without a stop
// - bus low longest, high shortest among masters
// - sent one seen as zero loses arbitration
// - on loss become slave receiver, release data
// - arbitration loss never emits a stop
// - loss sets flag and raises interrupt request
// - every clock fall restarts low timing, hold low; code follows a fall only in M_XFER, not in M_RSTA or M_STOP
// - low done but line low: wait high
// - release clock, then time high together
// - first high timeout pulls clock low again
// - own address or enabled general call flags addressed
// - addressed event interrupts only when enabled
// - data low while sending high loses
// - receive acknowledge driven high, seen low loses
// - start attempt on busy bus loses
// - repeated start as slave loses
// - stop not requested by master loses
// - lost flag holds until written one
module i2cas_ctrl
  import i2cas_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire i2cas_apb_req_s apb_req, // apb request from the master
  output i2cas_apb_rsp_s apb_rsp, // apb answer, registered
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value, always low
  output logic scl_oe_n, // low pulls the clock line low
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value, always low
  output logic sda_oe_n, // low pulls the data line low
  output logic irq // interrupt request, active high
);
  i2cas_st_s st;
  i2cas_st_s nx;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic apb_acc;
  logic apb_wr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic mbit;
  logic arb_chk;
  logic start_req;
  logic start_bad;
  logic rsta_bad;
  logic stop_bad;
  logic lose;
  logic addr_hit;

  // edges use the second and third sync stages only
  assign scl_rise = st.scl_q2 & ~st.scl_q3;
  assign scl_fall = ~st.scl_q2 & st.scl_q3;
  assign start_det = st.scl_q2 & st.scl_q3 & st.sda_q3 & ~st.sda_q2;
  assign stop_det = st.scl_q2 & st.scl_q3 & ~st.sda_q3 & st.sda_q2;

  // writes land on the edge where pready is seen high
  assign apb_acc = apb_req.psel & apb_req.penable & ~st.rsp.pready;
  assign apb_wr = apb_req.psel & apb_req.penable & st.rsp.pready & apb_req.pwrite;
  assign wr_ctrl = apb_wr & (apb_req.paddr == OFF_CTRL);
  assign wr_stat = apb_wr & (apb_req.paddr == OFF_STAT);
  assign wr_data = apb_wr & (apb_req.paddr == OFF_DATA);

  // bit the master wants on the data line; one means released
  assign mbit = (st.bitcnt < 4'd8) ? (st.tx ? st.txd[3'd7 - st.bitcnt[2:0]] : 1'b1)
                                    : (st.tx ? 1'b1 : st.txak);

  // data line compare at the clock rise
  assign arb_chk = (st.ms == M_XFER) & scl_rise & st.byte_pend & mbit & ~st.sda_q2 &
                   ((st.tx & (st.bitcnt < 4'd8)) | (~st.tx & (st.bitcnt == 4'd8)));
  assign start_req = wr_ctrl & apb_req.pwdata[CTRL_MST] & ~st.master;
  assign start_bad = start_req & st.busy;
  assign rsta_bad = wr_ctrl & apb_req.pwdata[CTRL_RSTA] & ~st.master;
  assign stop_bad = stop_det & ((st.ms == M_XFER) | (st.ms == M_RSTA));
  assign lose = arb_chk | start_bad | rsta_bad | stop_bad;
  assign addr_hit = (st.sr[7:1] == st.own_addr) | (st.general_call_accept_enable & (st.sr == GEN_CALL_ADDR));

  // next-state logic for the whole block
  always_comb
  begin
    nx = st;
    // two-stage synchronisers plus one history stage
    nx.scl_q1 = scl_i;
    nx.scl_q2 = st.scl_q1;
    nx.scl_q3 = st.scl_q2;
    nx.sda_q1 = sda_i;
    nx.sda_q2 = st.sda_q1;
    nx.sda_q3 = st.sda_q2;
    if ((st.ck == CK_LOW || st.ck == CK_HIGH) && st.cnt != 8'h00)
    begin
      nx.cnt = st.cnt - 8'h01;
    end

    // apb answer: one wait state, unmapped offsets get pslverr
    nx.rsp.pready = apb_acc;
    nx.rsp.pslverr = 1'b0;
    nx.rsp.prdata = 32'h0000_0000;
    if (apb_acc)
    begin
      unique case (apb_req.paddr)
        OFF_CTRL: nx.rsp.prdata = {26'h0, st.general_call_accept_enable, 1'b0, st.txak, st.tx, st.master, st.ien};
        OFF_ADDR: nx.rsp.prdata = {25'h0, st.own_addr};
        OFF_STAT: nx.rsp.prdata = {26'h0, st.rxak, st.slave_read_write_flag, st.arbitration_lost_flag, st.busy, st.addressed_as_slave_flag, st.tcf};
        OFF_DATA: nx.rsp.prdata = {24'h0, st.rxd};
        OFF_LOW: nx.rsp.prdata = {24'h0, st.low_cnt};
        OFF_HIGH: nx.rsp.prdata = {24'h0, st.high_cnt};
        default: nx.rsp.pslverr = 1'b1;
      endcase
    end

    // register writes; flag clears come first so a same-cycle set wins
    if (wr_ctrl)
    begin
      nx.ien = apb_req.pwdata[CTRL_IEN];
      nx.tx = apb_req.pwdata[CTRL_TX];
      nx.txak = apb_req.pwdata[CTRL_TXAK];
      nx.general_call_accept_enable = apb_req.pwdata[CTRL_GENERAL_CALL_ACCEPT_ENABLE];
      if (st.master && !apb_req.pwdata[CTRL_MST])
      begin
        nx.stop_req = 1'b1;
      end
      if (st.master && apb_req.pwdata[CTRL_RSTA])
      begin
        nx.rsta_req = 1'b1;
      end
      if (start_req && !st.busy)
      begin
        // start: pull data low while the clock stays high
        nx.master = 1'b1;
        nx.ms = M_START;
        nx.ck = CK_HIGH;
        nx.cnt = st.high_cnt;
        nx.sda_oe_n = 1'b0;
      end
    end
    if (apb_wr && apb_req.paddr == OFF_ADDR)
    begin
      nx.own_addr = apb_req.pwdata[6:0];
    end
    if (apb_wr && apb_req.paddr == OFF_LOW)
    begin
      nx.low_cnt = apb_req.pwdata[7:0];
    end
    if (apb_wr && apb_req.paddr == OFF_HIGH)
    begin
      nx.high_cnt = apb_req.pwdata[7:0];
    end
    if (wr_data && st.master)
    begin
      nx.txd = apb_req.pwdata[7:0];
      nx.byte_pend = 1'b1;
    end
    if (wr_stat)
    begin
      nx.tcf = st.tcf & ~apb_req.pwdata[STAT_TCF];
      nx.addressed_as_slave_flag = st.addressed_as_slave_flag & ~apb_req.pwdata[STAT_ADDRESSED_AS_SLAVE_FLAG];
      nx.arbitration_lost_flag = st.arbitration_lost_flag & ~apb_req.pwdata[STAT_ARBITRATION_LOST_FLAG];
    end

    // bus monitor: runs in every role so a loser still hears its address
    if (scl_rise)
    begin
      nx.sr = {st.sr[6:0], st.sda_q2};
      nx.bitcnt = st.bitcnt + 4'd1;
      if (st.bitcnt == 4'd8)
      begin
        nx.rxak = st.sda_q2;
      end
    end
    if (scl_fall && st.bitcnt == 4'd8)
    begin
      nx.rxd = st.sr;
      if (st.addr_ph && !st.master && addr_hit)
      begin
        nx.addressed_as_slave_flag = 1'b1;
        nx.slave_read_write_flag = st.sr[0];
        nx.slv_ack = 1'b1;
      end
    end
    if (scl_fall && st.bitcnt == 4'd9)
    begin
      nx.bitcnt = 4'd0;
      nx.addr_ph = 1'b0;
      nx.slv_ack = 1'b0;
      if (st.master && st.byte_pend)
      begin
        nx.byte_pend = 1'b0;
        nx.tcf = 1'b1;
      end
    end
    if (start_det)
    begin
      nx.busy = 1'b1;
      nx.bitcnt = 4'd0;
      nx.addr_ph = 1'b1;
    end
    if (stop_det)
    begin
      nx.busy = 1'b0;
      nx.bitcnt = 4'd0;
      nx.addr_ph = 1'b0;
      nx.slv_ack = 1'b0;
    end

    // master sequencer and clock engine
    if (st.ms == M_START)
    begin
      if (st.cnt == 8'h00)
      begin
        nx.ms = M_XFER;
        nx.ck = CK_LOW;
        nx.cnt = st.low_cnt;
        nx.scl_oe_n = 1'b0;
      end
    end
    else if (st.ms != M_IDLE)
    begin
      unique case (st.ck)
        CK_LOW:
        begin
          // hold the clock low for our own low time
          if (st.ms == M_XFER)
          begin
            nx.sda_oe_n = ~(st.byte_pend & ~mbit);
          end
          if (st.cnt == 8'h00)
          begin
            if (st.ms != M_XFER || st.byte_pend)
            begin
              nx.scl_oe_n = 1'b1;
              nx.ck = CK_WAITHI;
            end
            else if (st.stop_req)
            begin
              nx.ms = M_STOP;
              nx.stop_req = 1'b0;
              nx.sda_oe_n = 1'b0;
              nx.cnt = st.low_cnt;
            end
            else if (st.rsta_req)
            begin
              // release data first so it can fall again under a high clock
              nx.ms = M_RSTA;
              nx.rsta_req = 1'b0;
              nx.rs_ph = 1'b0;
              nx.sda_oe_n = 1'b1;
              nx.cnt = st.low_cnt;
            end
          end
        end
        CK_WAITHI:
        begin
          // someone still holds the clock low: wait for the line itself
          if (st.scl_q2)
          begin
            nx.ck = CK_HIGH;
            nx.cnt = st.high_cnt;
          end
        end
        CK_HIGH:
        begin
          if (scl_fall && st.ms == M_XFER)
          begin
            // a faster master ended high early: follow it and time our low
            nx.ck = CK_LOW;
            nx.cnt = st.low_cnt;
            nx.scl_oe_n = 1'b0;
          end
          else if (st.cnt == 8'h00)
          begin
            if (st.ms == M_XFER)
            begin
              nx.ck = CK_LOW;
              nx.cnt = st.low_cnt;
              nx.scl_oe_n = 1'b0;
            end
            else if (st.ms == M_STOP)
            begin
              nx.sda_oe_n = 1'b1;
              nx.ms = M_IDLE;
              nx.ck = CK_IDLE;
              nx.master = 1'b0;
            end
            else if (!st.rs_ph)
            begin
              nx.sda_oe_n = 1'b0;
              nx.rs_ph = 1'b1;
              nx.cnt = st.high_cnt;
            end
            else
            begin
              nx.ms = M_XFER;
              nx.ck = CK_LOW;
              nx.cnt = st.low_cnt;
              nx.scl_oe_n = 1'b0;
            end
          end
        end
        default:
        begin
          nx.ck = CK_IDLE;
        end
      endcase
    end

    // slave answers its address with an acknowledge while not master
    if (!nx.master)
    begin
      nx.sda_oe_n = ~nx.slv_ack;
    end

    // arbitration loss: drop straight to slave receive, no stop generated
    if (lose)
    begin
      nx.arbitration_lost_flag = 1'b1;
      nx.master = 1'b0;
      nx.tx = 1'b0;
      nx.ms = M_IDLE;
      nx.ck = CK_IDLE;
      nx.scl_oe_n = 1'b1;
      nx.sda_oe_n = 1'b1;
      nx.byte_pend = 1'b0;
      nx.stop_req = 1'b0;
      nx.rsta_req = 1'b0;
    end

    // one request line gated by the enable bit
    nx.irq = nx.ien & (nx.arbitration_lost_flag | nx.addressed_as_slave_flag | nx.tcf);
    nx.pin_lo = 1'b0;
  end

  // single state register; reset leaves an idle slave with lines released
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  assign apb_rsp = st.rsp;
  assign scl_o = st.pin_lo;
  assign sda_o = st.pin_lo;
  assign scl_oe_n = st.scl_oe_n;
  assign sda_oe_n = st.sda_oe_n;
  assign irq = st.irq;

  // checks on the block's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_lose_release;
    lose |=> (st.sda_oe_n && st.scl_oe_n && !st.master && !st.tx);
  endproperty
  a_lose_release: assert property (p_lose_release) else $error("lines not freed on loss");

  property p_lose_nostop;
    lose |=> (st.ms == M_IDLE) ##1 (st.ms != M_STOP);
  endproperty
  a_lose_nostop: assert property (p_lose_nostop) else $error("stop issued after loss");

  property p_lose_flag;
    (lose && nx.ien) |=> (st.arbitration_lost_flag && st.irq);
  endproperty
  a_lose_flag: assert property (p_lose_flag) else $error("loss not flagged");

  property p_arbitration_lost_flag_hold;
    (st.arbitration_lost_flag && !(wr_stat && apb_req.pwdata[STAT_ARBITRATION_LOST_FLAG])) |=> st.arbitration_lost_flag;
  endproperty
  a_arbitration_lost_flag_hold: assert property (p_arbitration_lost_flag_hold) else $error("lost flag dropped");

  property p_arbitration_lost_flag_clear;
    (wr_stat && apb_req.pwdata[STAT_ARBITRATION_LOST_FLAG] && !lose) |=> !st.arbitration_lost_flag;
  endproperty
  a_arbitration_lost_flag_clear: assert property (p_arbitration_lost_flag_clear) else $error("lost flag not cleared");

  property p_busy_start;
    (start_req && st.busy) |=> (st.arbitration_lost_flag && !st.master && st.ms == M_IDLE);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start on busy bus");

  property p_rsta_slave;
    rsta_bad |=> (st.arbitration_lost_flag && !st.rsta_req);
  endproperty
  a_rsta_slave: assert property (p_rsta_slave) else $error("restart as slave");

  property p_stop_foreign;
    (stop_det && st.ms == M_XFER) |=> (st.arbitration_lost_flag && st.sda_oe_n);
  endproperty
  a_stop_foreign: assert property (p_stop_foreign) else $error("foreign stop missed");

  property p_high_wait;
    (st.ck == CK_WAITHI && !st.scl_q2 && !lose) |=> (st.ck == CK_WAITHI && st.scl_oe_n);
  endproperty
  a_high_wait: assert property (p_high_wait) else $error("left high wait early");

  property p_low_hold;
    (st.ck == CK_LOW && st.cnt > 8'h01 && !lose) |=> !st.scl_oe_n [*2];
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("clock low cut short");

  property p_high_start;
    (st.ck == CK_WAITHI && st.scl_q2 && !lose) |=> (st.ck == CK_HIGH && st.cnt == $past(st.high_cnt));
  endproperty
  a_high_start: assert property (p_high_start) else $error("high timing not begun");

  property p_irq_gate;
    st.irq |-> (st.ien && (st.addressed_as_slave_flag || st.arbitration_lost_flag || st.tcf));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

  cover property (arb_chk);
  cover property (st.ck == CK_WAITHI ##1 st.ck == CK_WAITHI ##1 st.ck == CK_HIGH);
  cover property (st.ms == M_RSTA ##[1:600] st.ms == M_XFER);
  cover property ($rose(st.addressed_as_slave_flag));
endmodule : i2cas_ctrl

// file: hdl/i2cas_pkg.sv
// shared constants, register map and state types of the i2c arbitration and clock sync block
// assumes a 10 MHz pclk and an open-drain two-wire bus outside the chip
package i2cas_pkg;
  // timing of the bus clock phases, least times rounded up to whole pclk cycles
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_LOW_NS = 5000;
  localparam int unsigned T_HIGH_NS = 4000;
  localparam logic [7:0] LOW_CYC_RST = 8'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HIGH_CYC_RST = 8'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_LOW = 8'h10;
  localparam logic [7:0] OFF_HIGH = 8'h14;

  // control register fields
  localparam int CTRL_IEN = 0;
  localparam int CTRL_MST = 1;
  localparam int CTRL_TX = 2;
  localparam int CTRL_TXAK = 3;
  localparam int CTRL_RSTA = 4;
  localparam int CTRL_GENERAL_CALL_ACCEPT_ENABLE = 5;

  // status register fields
  localparam int STAT_TCF = 0;
  localparam int STAT_ADDRESSED_AS_SLAVE_FLAG = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_ARBITRATION_LOST_FLAG = 3;
  localparam int STAT_SRW = 4;
  localparam int STAT_RXAK = 5;

  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;

  typedef enum logic [1:0] {CK_IDLE, CK_LOW, CK_WAITHI, CK_HIGH} i2cas_ck_e;
  typedef enum logic [2:0] {M_IDLE, M_START, M_XFER, M_STOP, M_RSTA} i2cas_ms_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } i2cas_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } i2cas_apb_rsp_s;

  typedef struct packed {
    i2cas_ck_e ck;
    i2cas_ms_e ms;
    logic rs_ph;
    logic [7:0] cnt;
    logic master;
    logic tx;
    logic txak;
    logic ien;
    logic general_call_accept_enable;
    logic [6:0] own_addr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] sr;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic [3:0] bitcnt;
    logic addr_ph;
    logic busy;
    logic addressed_as_slave_flag;
    logic slave_read_write_flag;
    logic arbitration_lost_flag;
    logic tcf;
    logic rxak;
    logic byte_pend;
    logic stop_req;
    logic rsta_req;
    logic slv_ack;
    logic scl_q1;
    logic scl_q2;
    logic scl_q3;
    logic sda_q1;
    logic sda_q2;
    logic sda_q3;
    logic scl_oe_n;
    logic sda_oe_n;
    logic pin_lo;
    logic irq;
    i2cas_apb_rsp_s rsp;
  } i2cas_st_s;

  localparam i2cas_st_s ST_RST = '{
    ck: CK_IDLE, ms: M_IDLE, low_cnt: LOW_CYC_RST, high_cnt: HIGH_CYC_RST,
    own_addr: OWN_ADDR_RST, scl_q1: 1'b1, scl_q2: 1'b1, scl_q3: 1'b1,
    sda_q1: 1'b1, sda_q2: 1'b1, sda_q3: 1'b1, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
    default: '0};
endpackage : i2cas_pkg

// file: testbench/i2cas_peer.sv
// far-side party on the two-wire bus: stretches clock lows and pulls lines on command
// assumes scl is the resolved wire level and that pclk samples it, as the block does
`timescale 1ns/1ps
module i2cas_peer
(
  input wire logic pclk, // bench clock
  input wire logic presetn, // async reset, active low
  input wire logic scl, // resolved clock line
  input wire logic pull_scl, // bench holds the clock line low
  input wire logic pull_sda, // bench holds the data line low
  input wire logic [7:0] stretch, // own low period after each fall, 0 = none
  output logic scl_oe_n, // low pulls the clock line
  output logic sda_oe_n // low pulls the data line
);
  logic scl_q;
  logic [7:0] cnt;
  // each fall on the wire restarts our own low timing, whoever caused it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q <= 1'b1;
      cnt <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      if (scl_q && !scl)
        cnt <= stretch;
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
  end
  // let go once our low is counted; the wire only rises when nobody else pulls
  assign scl_oe_n = !(pull_scl || cnt != 8'h00);
  assign sda_oe_n = !pull_sda;
endmodule : i2cas_peer

// file: testbench/i2cas_ctrl_tb_top.sv
// self-checking bench for the i2c controller: apb tasks, bus monitor, stretching peer
// assumes open-drain lines with pull-ups, resolved here as the and of all enables
`timescale 1ns/1ps
module i2cas_ctrl_tb_top import i2cas_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  i2cas_apb_req_s req = '0;
  i2cas_apb_rsp_s rsp;
  logic d_scl_oe_n, d_sda_oe_n, p_scl_oe_n, p_sda_oe_n, irq;
  logic pull_scl = 1'b0, pull_sda = 1'b0, scl_d = 1'b1, sda_d = 1'b1, trk_clr = 1'b0;
  logic [7:0] stretch = 8'h00;
  logic [8:0] sh9 = '0;
  logic [15:0] run = '0, lo_min = '1, hi_max = '0;
  logic [31:0] d;
  logic e;
  int starts = 0, stops = 0, st0 = 0, miscompares = 0, samples_checked = 0, cyc = 0;
  logic [7:0] r_off [5] = '{OFF_CTRL, OFF_ADDR, OFF_STAT, OFF_LOW, OFF_HIGH};
  logic [31:0] r_rst [5] = '{32'h0, 32'h0, 32'h0, 32'h32, 32'h28};
  logic [7:0] c_byte [4] = '{8'hB5, 8'h00, 8'h00, 8'hB7};
  logic c_gc [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic c_hit [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  wire scl = d_scl_oe_n & p_scl_oe_n; // wired-and, pulled high when free
  wire sda = d_sda_oe_n & p_sda_oe_n;

  always #50 pclk = ~pclk;

  i2cas_ctrl i2cas_ctrl_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .scl_i(scl), .scl_o(), .scl_oe_n(d_scl_oe_n), .sda_i(sda), .sda_o(),
    .sda_oe_n(d_sda_oe_n), .irq(irq));
  i2cas_peer i2cas_peer_inst (.pclk(pclk), .presetn(presetn), .scl(scl), .pull_scl(pull_scl),
    .pull_sda(pull_sda), .stretch(stretch), .scl_oe_n(p_scl_oe_n), .sda_oe_n(p_sda_oe_n));

  // wire monitor: bits at clock rises, run lengths of each phase, starts and stops
  always @(posedge pclk)
  begin
    scl_d <= scl;
    sda_d <= sda;
    run <= (scl != scl_d) ? 16'h0001 : run + 16'h0001;
    if (scl && !scl_d)
    begin
      sh9 <= {sh9[7:0], sda};
      if (run < lo_min)
        lo_min <= run;
    end
    if (!scl && scl_d && run > hi_max)
      hi_max <= run;
    if (scl && scl_d && sda_d && !sda)
      starts <= starts + 1;
    if (scl && scl_d && !sda_d && sda)
      stops <= stops + 1;
    if (trk_clr)
    begin
      lo_min <= '1;
      hi_max <= '0;
    end
  end

  // a hang ends the run as a mismatch
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      chk("timeout", 32'h0, 32'h1);
      print_verdict();
    end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
    end
  endtask : chk

  // one apb transfer; request held one edge past the edge that sees pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv,
    output logic err);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    // only rising edges count; the bench timeout ends a wait that never answers
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    chk("pready", rsp.pready, 32'h1);
    rdv = rsp.prdata;
    err = rsp.pslverr;
    @(posedge pclk);
    req <= '0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, wd, x, er);
  endtask : wr

  task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] v;
    logic er;
    apb(1'b0, a, 32'h0, v, er);
    chk(n, v & m, x);
  endtask : rdc

  task wait_st(input int b, input logic v);
    logic [31:0] x;
    logic er;
    int i;
    for (i = 0; i < 300; i++)
    begin
      apb(1'b0, OFF_STAT, 32'h0, x, er);
      if (x[b] === v)
        break;
    end
    chk("stat_wait", x[b], v);
  endtask : wait_st

  task wait_scl(input logic v);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge pclk);
      if (scl === v)
        break;
    end
  endtask : wait_scl

  task hold(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold

  // bit-banged start, byte and a released ack bit at the 800 ns link rate
  task bb_frame(input logic [7:0] b);
    logic [8:0] f;
    int i;
    f = {b, 1'b1};
    pull_sda <= 1'b1;
    hold(4);
    pull_scl <= 1'b1;
    for (i = 8; i >= 0; i--)
    begin
      pull_sda <= !f[i];
      hold(4);
      pull_scl <= 1'b0;
      hold(4);
      pull_scl <= 1'b1;
    end
    hold(4);
  endtask : bb_frame

  task bb_stop;
    pull_sda <= 1'b1;
    hold(4);
    pull_scl <= 1'b0;
    hold(4);
    pull_sda <= 1'b0;
    hold(4);
  endtask : bb_stop

  task print_verdict;
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    hold(10);
    chk("oe_rst", {d_scl_oe_n, d_sda_oe_n, irq}, 32'h6);
    hold(10);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++)
      rdc("reg_rst", r_off[k], 32'hFF, r_rst[k]);
    apb(1'b0, 8'h18, 32'h0, d, e);
    chk("unmapped", {d, e}, 32'h1);
    wr(OFF_LOW, 32'h0A);
    wr(OFF_HIGH, 32'h08);
    // address byte, then a restart with a slow peer stretching every low
    wr(OFF_CTRL, 32'h07);
    wait_scl(1'b0);
    wr(OFF_DATA, 32'hA4);
    wait_st(STAT_TCF, 1'b1);
    chk("byte1", sh9, 32'h149);
    wr(OFF_STAT, 32'h01);
    stretch <= 8'd25;
    st0 = starts;
    wr(OFF_CTRL, 32'h17);
    wait_scl(1'b1);
    wait_scl(1'b0);
    trk_clr <= 1'b1;
    hold(1);
    trk_clr <= 1'b0;
    wr(OFF_DATA, 32'hA5);
    wait_st(STAT_TCF, 1'b1);
    chk("byte2", sh9, 32'h14B);
    chk("restart", starts - st0, 32'h1);
    chk("restart_nostop", stops, 32'h0);
    rdc("no_loss", OFF_STAT, 32'h08, 32'h0);
    chk("low_long", lo_min >= 25 && lo_min <= 30, 32'h1);
    chk("high_short", hi_max >= 8 && hi_max <= 16, 32'h1);
    stretch <= 8'h00;
    wr(OFF_STAT, 32'h01);
    wr(OFF_CTRL, 32'h05);
    wait_st(STAT_BUSY, 1'b0);
    // peer holds data low under a sent one
    st0 = stops;
    wr(OFF_CTRL, 32'h07);
    wait_scl(1'b0);
    wr(OFF_DATA, 32'hFF);
    wait_scl(1'b1);
    wait_scl(1'b0);
    pull_sda <= 1'b1;
    wait_st(STAT_ARBITRATION_LOST_FLAG, 1'b1);
    rdc("mst_drop", OFF_CTRL, 32'h02, 32'h0);
    chk("lines_free", {d_scl_oe_n, d_sda_oe_n}, 32'h3);
    chk("irq_loss", irq, 32'h1);
    chk("no_stop", stops - st0, 32'h0);
    wr(OFF_STAT, 32'h00);
    rdc("arbitration_lost_flag_hold", OFF_STAT, 32'h08, 32'h08);
    wr(OFF_STAT, 32'h08);
    rdc("arbitration_lost_flag_clr", OFF_STAT, 32'h08, 32'h0);
    pull_sda <= 1'b0;
    hold(8);
    // start attempted while the peer owns the bus, then restart as slave
    pull_sda <= 1'b1;
    wait_st(STAT_BUSY, 1'b1);
    wr(OFF_CTRL, 32'h03);
    rdc("busy_start", OFF_STAT, 32'h08, 32'h08);
    pull_sda <= 1'b0;
    wr(OFF_STAT, 32'h08);
    wr(OFF_CTRL, 32'h10);
    rdc("slave_rsta", OFF_STAT, 32'h08, 32'h08);
    wr(OFF_STAT, 32'h08);
    // receive with no-ack: peer pulls the released ack bit low
    wr(OFF_CTRL, 32'h0B);
    wait_scl(1'b0);
    wr(OFF_DATA, 32'h00);
    repeat (8)
    begin
      wait_scl(1'b1);
      wait_scl(1'b0);
    end
    pull_sda <= 1'b1;
    wait_st(STAT_ARBITRATION_LOST_FLAG, 1'b1);
    pull_sda <= 1'b0;
    rdc("rx_ack_drop", OFF_CTRL, 32'h02, 32'h0);
    wr(OFF_STAT, 32'h08);
    // peer makes a start and stop inside our high phase
    wr(OFF_CTRL, 32'h07);
    wait_scl(1'b0);
    wr(OFF_DATA, 32'hFF);
    wait_scl(1'b1);
    pull_sda <= 1'b1;
    hold(2);
    pull_sda <= 1'b0;
    wait_st(STAT_ARBITRATION_LOST_FLAG, 1'b1);
    rdc("foreign_stop", OFF_CTRL, 32'h02, 32'h0);
    wr(OFF_STAT, 32'h08);
    // own address, general call on and off, foreign address
    wr(OFF_ADDR, 32'h5A);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_CTRL, {26'h0, c_gc[k], 5'h00});
      bb_frame(c_byte[k]);
      chk("ack", sh9[0], !c_hit[k]);
      rdc("addressed_as_slave_flag", OFF_STAT, 32'h02, {30'h0, c_hit[k], 1'b0});
      chk("irq_off", irq, 32'h0);
      wr(OFF_CTRL, {26'h0, c_gc[k], 5'h01});
      hold(2);
      chk("irq_on", irq, c_hit[k]);
      if (c_hit[k])
      begin
        rdc("srw", OFF_STAT, 32'h10, {27'h0, c_byte[k][0], 4'h0});
        // software follows the direction flag: master read means we transmit
        wr(OFF_CTRL, {26'h0, c_gc[k], 2'h0, c_byte[k][0], 2'h1});
        rdc("tx_dir", OFF_CTRL, 32'h04, {29'h0, c_byte[k][0], 2'h0});
      end
      bb_stop();
      wr(OFF_STAT, 32'h02);
      wr(OFF_CTRL, 32'h00);
    end
    print_verdict();
  end
endmodule : i2cas_ctrl_tb_top
